// ---- rtl/slh_host_regs.v ----
// Host register bank of a serial-link controller: identity, node address,
// last transmit handshake, control, incoming packet filter, self-ID capture.
// Assumes host strobes are synchronous to mclk_in.
//
// What this block does
// RQ1: Host uses chip select, index, write line.
// RQ2: Asynchronous active-low reset restores initial state.
// RQ3: Core tick derived at half link clock.
// RQ4: Read-only identification register at 00h.
// RQ5: Version low half, revision high half.
// RQ6: Node register at 04h, resets FFFF_0000h.
// RQ7: Ids writable; handshake writable only when unlocked.
// RQ8: Bus and node form source and filter.
// RQ9: Bus identity 3FFh always accepted.
// RQ10: Node 3Fh accepted unless blocking bits say.
// RQ11: Bits 24-27 hold last transmit handshake.
// RQ12: Control register at 08h, resets zero.
// RQ13: Identity valid selects own-node acceptance.
// RQ14: Control bit 1 captures self-ID into FIFO.
// RQ15: Second quadlet must invert the first.
// RQ16: Group tagged 1h good, Dh wrong.
// RQ17: Reserved reads zero except node register reserved bits, which read ones; read-only writes ignored.
`timescale 1ns/1ns
`include "slh_consts.vh"

module slh_host_regs (
   input wire mclk_in,
   input wire rst_n_in,
   input wire cs_n_in,
   input wire wr_n_in,
   input wire [7:0] addr_in,
   input wire [31:0] data_in,
   output reg [31:0] data_out,
   input wire diag_write_unlock_in,
   input wire tx_ack_valid_in,
   input wire [3:0] tx_ack_code_in,
   input wire rx_hdr_valid_in,
   input wire [9:0] rx_dest_bus_in,
   input wire [5:0] rx_dest_node_in,
   input wire [1:0] bus_dependent_block_bits_in,
   output reg rx_accept_out,
   output reg rx_reject_out,
   output wire [15:0] src_id_out,
   output wire own_id_valid_out,
   output wire capture_selfid_enable_out,
   output wire core_tick_out,
   input wire sid_valid_in,
   input wire [31:0] sid_data_in,
   input wire sid_end_in,
   output wire general_receive_fifo_wr_out,
   output wire [31:0] general_receive_fifo_data_out,
   output wire general_receive_fifo_last_out
);
   reg [9:0] bus_id_field_q;
   reg [5:0] node_id_field_q;
   reg [3:0] last_tx_handshake_code_q;
   reg own_id_valid_q;
   reg capture_selfid_enable_q;
   reg [1:0] tick_cnt_q;
   reg tick_q;

   localparam [31:0] NODE_RST = `SLH_NODE_RESET;
   localparam [31:0] CTRL_RST = `SLH_CTRL_RESET;

   wire host_wr;
   wire host_rd;

   // Field view of the node register. Reserved bits keep their reset
   // ones, so a read after reset shows the full reset word.
   function [31:0] node_word;
      input [9:0] bus;
      input [5:0] node;
      input [3:0] ack;
      begin
         node_word = NODE_RST;
         node_word[`SLH_BUS_MSB:`SLH_BUS_LSB] = bus;
         node_word[`SLH_NODE_MSB:`SLH_NODE_LSB] = node;
         node_word[`SLH_ACK_MSB:`SLH_ACK_LSB] = ack;
      end
   endfunction

   // Broadcast test on either address part
   function is_bcast;
      input [9:0] bus;
      input [5:0] node;
      input sel_node;
      begin
         if (sel_node) begin
            is_bcast = (node == `SLH_BCAST_NODE);
         end else begin
            is_bcast = (bus == `SLH_BCAST_BUS);
         end
      end
   endfunction

   assign host_wr = !cs_n_in && !wr_n_in; // RQ1
   assign host_rd = !cs_n_in && wr_n_in; // RQ1

   // Core tick: one-cycle enable at the derived core rate
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tick_cnt_q <= 2'h0;
         tick_q <= 1'b0;
      end else begin
         if ({30'h0, tick_cnt_q} == (`SLH_TICK_DIV - 1)) begin
            tick_cnt_q <= 2'h0;
            tick_q <= 1'b1; // RQ3
         end else begin
            tick_cnt_q <= tick_cnt_q + 2'h1;
            tick_q <= 1'b0;
         end
      end
   end
   assign core_tick_out = tick_q;

   // Node register; hardware handshake capture wins over a host write
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bus_id_field_q <= NODE_RST[`SLH_BUS_MSB:`SLH_BUS_LSB]; // RQ2 RQ6
         node_id_field_q <= NODE_RST[`SLH_NODE_MSB:`SLH_NODE_LSB];
         last_tx_handshake_code_q <= NODE_RST[`SLH_ACK_MSB:`SLH_ACK_LSB];
      end else begin
         if (host_wr && addr_in == `SLH_IDX_NODE) begin
            bus_id_field_q <= data_in[`SLH_BUS_MSB:`SLH_BUS_LSB]; // RQ7
            node_id_field_q <= data_in[`SLH_NODE_MSB:`SLH_NODE_LSB]; // RQ7
            if (diag_write_unlock_in) begin
               last_tx_handshake_code_q <= data_in[`SLH_ACK_MSB:`SLH_ACK_LSB]; // RQ7
            end
         end
         if (tx_ack_valid_in) begin
            last_tx_handshake_code_q <= tx_ack_code_in; // RQ11
         end
      end
   end

   // Control register: only the two defined bits are held
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         own_id_valid_q <= CTRL_RST[`SLH_CTRL_OWN_ID_VALID]; // RQ12
         capture_selfid_enable_q <= CTRL_RST[`SLH_CTRL_CAPTURE_SELFID];
      end else if (host_wr && addr_in == `SLH_IDX_CTRL) begin
         own_id_valid_q <= data_in[`SLH_CTRL_OWN_ID_VALID]; // RQ12
         capture_selfid_enable_q <= data_in[`SLH_CTRL_CAPTURE_SELFID]; // RQ17
      end
   end
   assign own_id_valid_out = own_id_valid_q;
   assign capture_selfid_enable_out = capture_selfid_enable_q;
   assign src_id_out = {bus_id_field_q, node_id_field_q}; // RQ8

   // Read data, registered; unmapped indices read zero
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         data_out <= 32'h00000000;
      end else if (host_rd) begin
         case (addr_in)
            `SLH_IDX_IDENT: data_out <= {`SLH_REVISION_CODE, `SLH_VERSION_CODE}; // RQ4 RQ5
            `SLH_IDX_NODE: data_out <= node_word(bus_id_field_q, node_id_field_q,
                                                 last_tx_handshake_code_q); // RQ17
            `SLH_IDX_CTRL: data_out <= {30'h00000000, capture_selfid_enable_q,
                                        own_id_valid_q};
            default: data_out <= 32'h00000000;
         endcase
      end
   end

   // Incoming filter. Block bit 0 refuses broadcast on the global bus,
   // bit 1 broadcast on our own bus number.
   reg bus_hit;
   reg node_hit;
   always @* begin
      bus_hit = is_bcast(rx_dest_bus_in, rx_dest_node_in, 1'b0) ||
                (rx_dest_bus_in == bus_id_field_q); // RQ8 RQ9
      if (is_bcast(rx_dest_bus_in, rx_dest_node_in, 1'b1)) begin
         if (is_bcast(rx_dest_bus_in, rx_dest_node_in, 1'b0)) begin
            node_hit = !bus_dependent_block_bits_in[0]; // RQ10
         end else begin
            node_hit = !bus_dependent_block_bits_in[1]; // RQ10
         end
      end else begin
         node_hit = own_id_valid_q && (rx_dest_node_in == node_id_field_q); // RQ13
      end
   end

   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_accept_out <= 1'b0;
         rx_reject_out <= 1'b0;
      end else begin
         rx_accept_out <= rx_hdr_valid_in && bus_hit && node_hit;
         rx_reject_out <= rx_hdr_valid_in && !(bus_hit && node_hit);
      end
   end

   slh_selfid_capture u_sid (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .tick_in(tick_q),
      .enable_in(capture_selfid_enable_q), // RQ14
      .sid_valid_in(sid_valid_in),
      .sid_data_in(sid_data_in),
      .sid_end_in(sid_end_in),
      .general_receive_fifo_wr_out(general_receive_fifo_wr_out),
      .general_receive_fifo_data_out(general_receive_fifo_data_out),
      .general_receive_fifo_last_out(general_receive_fifo_last_out)
   );
endmodule

// ---- rtl/slh_consts.vh ----
// Constants for the serial-link host register front end.
// Assumes inclusion by bare name from each design file.
`ifndef SLH_CONSTS_VH
`define SLH_CONSTS_VH

// Register indices on the 8-bit host index lines
`define SLH_IDX_IDENT 8'h00
`define SLH_IDX_NODE 8'h04
`define SLH_IDX_CTRL 8'h08

// Reset values
`define SLH_NODE_RESET 32'hffff0000
`define SLH_CTRL_RESET 32'h00000000
// Identification codes, values arbitrary
`define SLH_VERSION_CODE 16'h0101
`define SLH_REVISION_CODE 16'h0001

// Node register field positions
`define SLH_BUS_LSB 0
`define SLH_BUS_MSB 9
`define SLH_NODE_LSB 10
`define SLH_NODE_MSB 15
`define SLH_ACK_LSB 24
`define SLH_ACK_MSB 27

// Control register bit positions
`define SLH_CTRL_OWN_ID_VALID 0
`define SLH_CTRL_CAPTURE_SELFID 1

// Broadcast identities
`define SLH_BCAST_BUS 10'h3ff
`define SLH_BCAST_NODE 6'h3f

// Self-identification status codes
`define SLH_SID_GOOD 4'h1
`define SLH_SID_BAD 4'hd

// Clock rates in kHz; core tick is the link clock divided down
`define SLH_LINK_CLK_KHZ 49152
`define SLH_CORE_CLK_KHZ 24576
`define SLH_TICK_DIV (`SLH_LINK_CLK_KHZ / `SLH_CORE_CLK_KHZ)

`endif

// ---- rtl/slh_selfid_capture.v ----
// Self-identification capture: pairs quadlets and tags the group status.
// Assumes quadlets arrive qualified by the core tick from the register bank.
`timescale 1ns/1ns
`include "slh_consts.vh"

module slh_selfid_capture (
   input wire mclk_in,
   input wire rst_n_in,
   input wire tick_in,
   input wire enable_in,
   input wire sid_valid_in,
   input wire [31:0] sid_data_in,
   input wire sid_end_in,
   output reg general_receive_fifo_wr_out,
   output reg [31:0] general_receive_fifo_data_out,
   output reg general_receive_fifo_last_out
);
   localparam S_FIRST = 3'b001;
   localparam S_SECOND = 3'b010;
   localparam S_TRAIL = 3'b100;

   reg [2:0] state_q;
   reg [31:0] first_q;
   reg bad_q;

   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q <= S_FIRST;
         first_q <= 32'h00000000;
         bad_q <= 1'b0;
         general_receive_fifo_wr_out <= 1'b0;
         general_receive_fifo_data_out <= 32'h00000000;
         general_receive_fifo_last_out <= 1'b0;
      end else begin
         general_receive_fifo_wr_out <= 1'b0;
         general_receive_fifo_last_out <= 1'b0;
         if (!enable_in) begin
            state_q <= S_FIRST;
            bad_q <= 1'b0;
         end else if (tick_in) begin
            case (state_q)
               S_FIRST: begin
                  if (sid_end_in) begin
                     state_q <= S_TRAIL;
                  end else if (sid_valid_in) begin
                     first_q <= sid_data_in;
                     general_receive_fifo_wr_out <= 1'b1; // RQ14
                     general_receive_fifo_data_out <= sid_data_in;
                     state_q <= S_SECOND;
                  end
               end
               S_SECOND: begin
                  if (sid_end_in) begin
                     // Odd quadlet count marks the group wrong
                     bad_q <= 1'b1;
                     state_q <= S_TRAIL;
                  end else if (sid_valid_in) begin
                     if (sid_data_in != ~first_q) begin
                        bad_q <= 1'b1; // RQ15
                     end
                     general_receive_fifo_wr_out <= 1'b1;
                     general_receive_fifo_data_out <= sid_data_in;
                     state_q <= S_FIRST;
                  end
               end
               S_TRAIL: begin
                  general_receive_fifo_wr_out <= 1'b1;
                  general_receive_fifo_last_out <= 1'b1;
                  general_receive_fifo_data_out <= {28'h0000000,
                     bad_q ? `SLH_SID_BAD : `SLH_SID_GOOD}; // RQ16
                  bad_q <= 1'b0;
                  state_q <= S_FIRST;
               end
               default: begin
                  state_q <= S_FIRST;
               end
            endcase
         end
      end
   end
endmodule

// ---- dv/slh_host_model.sv ----
// Host-bus processor model: register reads and writes.
// Assumes the bank takes a request on the edge with select low.
`timescale 1ns/1ns
module slh_host_model (
   input wire mclk_in,
   input wire [31:0] data_in,
   output reg cs_n_out,
   output reg wr_n_out,
   output reg [7:0] addr_out,
   output reg [31:0] data_out
);
   initial begin
      cs_n_out = 1'b1;
      wr_n_out = 1'b1;
      addr_out = 8'h00;
      data_out = 32'h0;
   end
   // Released select, address and data lines go to the inverse so stale values never pass; the write line keeps its level
   task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] q);
      begin
         @(posedge mclk_in);
         #1;
         cs_n_out = 1'b0;
         wr_n_out = !w;
         addr_out = a;
         data_out = d;
         @(posedge mclk_in);
         #1;
         q = data_in;
         cs_n_out = 1'b1;
         addr_out = ~a;
         data_out = ~d;
      end
   endtask
endmodule

// ---- dv/slh_host_regs_sva.sv ----
// Checker for the host register bank.
// Assumes binding to slh_host_regs; all ports on mclk_in.
`timescale 1ns/1ns
`include "slh_consts.vh"
module slh_host_regs_chk (
   input wire mclk_in,
   input wire rst_n_in,
   input wire cs_n_in,
   input wire wr_n_in,
   input wire [7:0] addr_in,
   input wire [31:0] data_in,
   input wire [31:0] data_out,
   input wire rx_hdr_valid_in,
   input wire [9:0] rx_dest_bus_in,
   input wire [5:0] rx_dest_node_in,
   input wire [1:0] bus_dependent_block_bits_in,
   input wire rx_accept_out,
   input wire rx_reject_out,
   input wire [15:0] src_id_out,
   input wire own_id_valid_out,
   input wire capture_selfid_enable_out,
   input wire core_tick_out,
   input wire sid_valid_in,
   input wire [31:0] sid_data_in,
   input wire sid_end_in,
   input wire general_receive_fifo_wr_out,
   input wire [31:0] general_receive_fifo_data_out,
   input wire general_receive_fifo_last_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   wire rd = !cs_n_in && wr_n_in;
   wire hv = rx_hdr_valid_in;
   property p_one; hv |=> rx_accept_out != rx_reject_out; endproperty
   a_one: assert property (p_one) else $error("filter answer not single");
   property p_bc;
      hv && rx_dest_bus_in == 10'h3ff && rx_dest_node_in == 6'h3f
         && !bus_dependent_block_bits_in[0] |=> rx_accept_out;
   endproperty
   a_bc: assert property (p_bc) else $error("broadcast refused");
   property p_idv; hv && !own_id_valid_out && rx_dest_node_in != 6'h3f |=> rx_reject_out;
   endproperty
   a_idv: assert property (p_idv) else $error("own node taken while invalid");
   property p_own;
      hv && own_id_valid_out && rx_dest_node_in != 6'h3f
         && {rx_dest_bus_in, rx_dest_node_in} == src_id_out |=> rx_accept_out;
   endproperty
   a_own: assert property (p_own) else $error("own node refused");
   property p_tick; core_tick_out |=> !core_tick_out ##1 core_tick_out; endproperty
   a_tick: assert property (p_tick) else $error("core tick not half rate");
   property p_id;
      rd && addr_in == 8'h00 |=> data_out == {`SLH_REVISION_CODE, `SLH_VERSION_CODE};
   endproperty
   a_id: assert property (p_id) else $error("identification read wrong");
   property p_hole; rd && addr_in > 8'h08 |=> data_out == 32'h0; endproperty
   a_hole: assert property (p_hole) else $error("unmapped read not zero");
   property p_ctl;
      !cs_n_in && !wr_n_in && addr_in == 8'h08 |=> own_id_valid_out == $past(data_in[0])
         && capture_selfid_enable_out == $past(data_in[1]);
   endproperty
   a_ctl: assert property (p_ctl) else $error("control bits not written");
   property p_sid;
      capture_selfid_enable_out && core_tick_out && sid_valid_in && !sid_end_in
         |=> general_receive_fifo_wr_out
         && general_receive_fifo_data_out == $past(sid_data_in);
   endproperty
   a_sid: assert property (p_sid) else $error("quadlet not stored");
   c_acc: cover property (hv ##1 rx_accept_out);
   c_trl: cover property (general_receive_fifo_wr_out && general_receive_fifo_last_out);
   c_node: cover property (rd && addr_in == 8'h04);
endmodule
bind slh_host_regs slh_host_regs_chk slh_host_regs_chk_inst (.*);

// ---- dv/tb.sv ----
// Self-checking bench for the host register bank.
// Assumes the host model drives the register bus.
`timescale 1ns/1ns
`include "slh_consts.vh"
module tb;
   reg mclk_in = 1'b0;
   reg rst_n_in = 1'b0;
   reg unl = 1'b0, ackv = 1'b0, hv = 1'b0, sv = 1'b0, se = 1'b0, ctl0 = 1'b0;
   reg [3:0] ack_code = 4'h0;
   reg [9:0] dbus = 10'h0;
   reg [5:0] dnode = 6'h0;
   reg [1:0] blk = 2'h0;
   reg [31:0] sdat = 32'h0, q, w, nd = 32'hffff0000;
   wire cs_n, wr_n, acc, rej, idv, cap, tick, gw, gl;
   wire [7:0] addr;
   wire [31:0] wdat, rdat, gd;
   wire [15:0] src;
   integer errors = 0, tests_run = 0, i;
   initial forever #20 mclk_in = ~mclk_in;
   slh_host_model slh_host_model_inst (.mclk_in(mclk_in), .data_in(rdat),
      .cs_n_out(cs_n), .wr_n_out(wr_n), .addr_out(addr), .data_out(wdat));
   slh_host_regs slh_host_regs_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
      .cs_n_in(cs_n), .wr_n_in(wr_n), .addr_in(addr), .data_in(wdat), .data_out(rdat),
      .diag_write_unlock_in(unl), .tx_ack_valid_in(ackv), .tx_ack_code_in(ack_code),
      .rx_hdr_valid_in(hv), .rx_dest_bus_in(dbus), .rx_dest_node_in(dnode),
      .bus_dependent_block_bits_in(blk), .rx_accept_out(acc), .rx_reject_out(rej),
      .src_id_out(src), .own_id_valid_out(idv), .capture_selfid_enable_out(cap),
      .core_tick_out(tick), .sid_valid_in(sv), .sid_data_in(sdat), .sid_end_in(se),
      .general_receive_fifo_wr_out(gw), .general_receive_fifo_data_out(gd),
      .general_receive_fifo_last_out(gl));
   task test_done;
      begin
         $display("errors %0d tests_run %0d", errors, tests_run);
         if (errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   task chk(input [63:0] nm, input [31:0] e, input [31:0] s);
      begin
         tests_run = tests_run + 1;
         if (s !== e) begin
            errors = errors + 1;
            $display("unexpected %0s exp %h got %h", nm, e, s);
         end
      end
   endtask
   task lim(input integer k);
      if (k >= 8) begin
         errors = errors + 1;
         test_done;
      end
   endtask
   task step;
      begin
         @(posedge mclk_in);
         #1;
      end
   endtask
   task rd(input [7:0] a, input [31:0] e);
      begin
         slh_host_model_inst.xfer(1'b0, a, 32'h0, q);
         chk("rdata", e, q);
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      slh_host_model_inst.xfer(1'b1, a, d, q);
   endtask
   function ex(input [9:0] b, input [5:0] n, input [1:0] k);
      ex = (b == 10'h3ff || b == nd[9:0])
         && (n == 6'h3f ? !k[b != 10'h3ff] : ctl0 && n == nd[15:10]);
   endfunction
   task flt(input [9:0] b, input [5:0] n, input [1:0] k);
      begin
         step;
         {hv, dbus, dnode, blk} = {1'b1, b, n, k};
         step;
         hv = 1'b0;
         chk("accept", {31'h0, ex(b, n, k)}, {31'h0, acc});
         chk("reject", {31'h0, !ex(b, n, k)}, {31'h0, rej});
      end
   endtask
   // Inputs only count on tick cycles, so wait for one first
   task sq(input v, input en, input [31:0] d);
      integer j;
      begin
         j = 0;
         step;
         while (tick !== 1'b1 && j < 8) begin
            step;
            j = j + 1;
         end
         lim(j);
         {sv, se, sdat} = {v, en, d};
         step;
         {sv, se, sdat} = {1'b0, 1'b0, ~d};
         if (v) chk("fifodata", d, gd);
      end
   endtask
   task grp(input integer n, input bad);
      integer k;
      begin
         for (k = 0; k < n; k = k + 1) begin
            w = k[0] ? ~w : $urandom;
            sq(1'b1, 1'b0, (bad && k == 1) ? w ^ 32'h1 : w);
         end
         sq(1'b0, 1'b1, 32'h0);
         k = 0;
         while (gw !== 1'b1 && k < 8) begin
            step;
            k = k + 1;
         end
         lim(k);
         chk("trailer", {28'h0, (bad || n % 2) ? 4'hd : 4'h1}, gd);
         chk("last", 32'h1, {31'h0, gl});
      end
   endtask
   initial begin
      q = $urandom(32'h679d);
      repeat (5) @(posedge mclk_in);
      #1 rst_n_in = 1'b1;
      rd(8'h00, {`SLH_REVISION_CODE, `SLH_VERSION_CODE});
      rd(8'h04, 32'hffff0000);
      rd(8'h08, 32'h0);
      wr(8'h00, 32'h0);
      rd(8'h00, {`SLH_REVISION_CODE, `SLH_VERSION_CODE});
      rd(8'h0c, 32'h0);
      $display("test reset values done");
      for (i = 0; i < 4; i = i + 1) begin
         w = $urandom;
         unl = i[0];
         wr(8'h04, w);
         nd = {4'hf, unl ? w[27:24] : nd[27:24], 8'hff, w[15:0]};
         rd(8'h04, nd);
         chk("src", {16'h0, nd[9:0], nd[15:10]}, {16'h0, src});
      end
      unl = 1'b0;
      ack_code = $urandom;
      step;
      ackv = 1'b1;
      step;
      ackv = 1'b0;
      nd[27:24] = ack_code;
      rd(8'h04, nd);
      // Unlocked host write and handshake capture on one edge
      unl = 1'b1;
      w = $urandom;
      ack_code = ~w[27:24];
      fork
         wr(8'h04, w);
         begin
            step;
            ackv = 1'b1;
            step;
            ackv = 1'b0;
         end
      join
      unl = 1'b0;
      nd = {4'hf, ack_code, 8'hff, w[15:0]};
      rd(8'h04, nd);
      $display("test node register done");
      for (i = 0; i < 4; i = i + 1) begin
         w = (i < 2) ? i : $urandom;
         ctl0 = w[0];
         wr(8'h08, w);
         rd(8'h08, {30'h0, w[1:0]});
         flt(10'h3ff, 6'h3f, i[1:0]);
         flt(nd[9:0], nd[15:10], 2'h0);
         repeat (6) begin
            w = $urandom;
            flt(w[1] ? 10'h3ff : (w[0] ? nd[9:0] : w[17:8]),
               w[3] ? 6'h3f : (w[2] ? nd[15:10] : w[23:18]), w[5:4]);
         end
      end
      $display("test filter done");
      wr(8'h08, 32'h2);
      ctl0 = 1'b0;
      grp(4, 1'b0);
      grp(4, 1'b1);
      grp(3, 1'b0);
      $display("test self-id done");
      #10 rst_n_in = 1'b0;
      #5 chk("src", 32'h0, {16'h0, src});
      step;
      rst_n_in = 1'b1;
      rd(8'h04, 32'hffff0000);
      rd(8'h08, 32'h0);
      $display("test async reset done");
      test_done;
   end
endmodule
